//--- design/switch_serial_device.sv
// Contract
// RULE1: sample serial input on falling clock edge
// RULE2: shift next output bit on rising edge
// RULE3: host sends sixteen bits, msb first
// RULE4: frame carries five-bit register address
// RULE5: chip select rise commits received frame
// RULE6: chip select fall captures status word
// RULE7: data out driven only while selected
// RULE8: ignore clock and data while deselected
// RULE9: host selects only with clock low
// RULE10: host keeps clock low when idle; after reset the host gives four clock pulses with select high
// RULE11: open-drain fault flag low on fault
// RULE12: reset low clears registers, enters sleep
// RULE13: reset rising starts the watchdog
// RULE14: direct input, wake or reset wakes
// RULE15: direct inputs switch outputs directly
// RULE16: first direct input clocks the pwm
// RULE17: logic supply loss enters fail-safe
// RULE18: sense source select and tri-state settings
// RULE19: host keeps pwm clock within limits
// RULE20: commit only frames of exactly sixteen bits; the five-bit edge count wraps, so 48-bit frames also commit
`timescale 1ns/100ps
`default_nettype none
module switch_serial_device #(
   parameter int WDOG_LIMIT = switch_serial_pkg::WDOG_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   serial_link_if.device link,
   input wire logic reset_pin_n,
   input wire logic wake,
   input wire logic [3:0] direct_inputs,
   input wire logic vdd_fail,
   input wire logic [3:0] channel_fault,
   output logic [3:0] high_side_outputs,
   output logic fault_flag_out,
   output logic fault_flag_oe,
   output logic sense_temp_sel,
   output logic [1:0] sense_channel,
   output logic current_sense_oe,
   output logic sleeping,
   output logic fail_safe
);
   localparam int FB = switch_serial_pkg::FRAME_BITS;
   localparam int DB = switch_serial_pkg::DATA_BITS;

   ////////////////////////////////////////////////////////////////////////////
   // Link clock domain
   logic link_rst;
   logic [4:0] fall_cnt_q;
   logic [4:0] rise_cnt_q;
   logic [FB-1:0] rx_q;
   logic so_bit_q;
   logic [4:0] rise_start_q;
   logic [FB-1:0] snap_q;
   logic [4:0] tx_idx;
   logic first_bit;

   sync2 #(.WIDTH(1)) u_link_rst (.clk(link.sclk), .din(reset), .dout(link_rst));

   // Serial input sampled on falling edge while selected
   // Edges with select high (the host's start-up pulses) clear the link side
   always_ff @(negedge link.sclk) begin
      if (link_rst || link.cs_n) begin // [RULE8]
         fall_cnt_q <= 5'h00;
         rx_q <= '0;
      end else begin
         fall_cnt_q <= fall_cnt_q + 5'h01; // [RULE20]
         rx_q <= {rx_q[FB-2:0], link.si}; // [RULE1] [RULE3]
      end
   end

   // Output bit index: bit 15 first, then one lower per rising edge
   assign tx_idx = 5'(5'd15 - (rise_cnt_q - rise_start_q));
   assign first_bit = (rise_cnt_q == rise_start_q);

   always_ff @(posedge link.sclk) begin
      if (link_rst || link.cs_n) begin // [RULE8]
         rise_cnt_q <= 5'h00;
         so_bit_q <= 1'b0;
      end else begin
         rise_cnt_q <= rise_cnt_q + 5'h01;
         so_bit_q <= snap_q[tx_idx[3:0]]; // [RULE2]
      end
   end

   // Driver enabled by the select pin alone
   assign link.so_oe = !link.cs_n; // [RULE7]
   assign link.so_out = first_bit ? snap_q[FB-1] : so_bit_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers into the system clock
   logic cs_n_s;
   logic rst_pin_s;
   logic wake_s;
   logic vdd_fail_s;
   logic [3:0] din_s;
   logic cs_n_q;
   logic rst_pin_q;
   logic pwm_clk_q;

   sync2 #(.WIDTH(8)) u_pins (
      .clk(clk),
      .din({link.cs_n, reset_pin_n, wake, vdd_fail, direct_inputs}),
      .dout({cs_n_s, rst_pin_s, wake_s, vdd_fail_s, din_s})
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         cs_n_q <= 1'b1;
         rst_pin_q <= 1'b0;
         pwm_clk_q <= 1'b0;
      end else begin
         cs_n_q <= cs_n_s;
         rst_pin_q <= rst_pin_s;
         pwm_clk_q <= din_s[0];
      end
   end

   // Edge decodes
   wire cs_fall = cs_n_q && !cs_n_s;
   wire cs_rise = !cs_n_q && cs_n_s;
   wire rst_rise = !rst_pin_q && rst_pin_s;
   wire pwm_tick = !pwm_clk_q && din_s[0];

   ////////////////////////////////////////////////////////////////////////////
   // Frame capture and commit
   logic [4:0] fall_start_q;
   logic [DB-1:0] regs_q [switch_serial_pkg::NUM_REGS];
   logic [3:0] out_state_q;
   logic wdog_run_q;
   logic wdog_exp_q;
   logic [31:0] wdog_cnt_q;
   logic sleep_q;
   logic fsafe_q;

   // Link counters are still while the clock is parked low
   wire [4:0] bits_seen = 5'(fall_cnt_q - fall_start_q);
   wire frame_ok = cs_rise && (bits_seen == 5'(FB)); // [RULE20]
   wire [4:0] frame_addr = rx_q[switch_serial_pkg::ADDR_MSB:switch_serial_pkg::ADDR_LSB]; // [RULE4]
   wire [FB-1:0] status_word = {channel_fault, out_state_q, sleep_q, fsafe_q, wdog_exp_q, 5'h00};

   always_ff @(posedge clk) begin
      if (reset) begin
         fall_start_q <= 5'h00;
         rise_start_q <= 5'h00;
         snap_q <= '0;
      end else if (cs_fall) begin
         fall_start_q <= fall_cnt_q;
         rise_start_q <= rise_cnt_q;
         snap_q <= status_word; // [RULE6]
      end
   end

   // Register file, cleared by the reset pin
   always_ff @(posedge clk) begin
      for (int i = 0; i < switch_serial_pkg::NUM_REGS; i++) begin
         if (reset || !rst_pin_s) begin
            regs_q[i] <= switch_serial_pkg::REG_RESET; // [RULE12]
         end else if (frame_ok && frame_addr == 5'(i)) begin
            regs_q[i] <= rx_q[DB-1:0]; // [RULE5]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sleep, watchdog and fail-safe
   wire [DB-1:0] mode = regs_q[switch_serial_pkg::REG_MODE];
   wire wake_any = (|din_s) || wake_s || rst_rise; // [RULE14]
   wire wdog_done = wdog_run_q && (wdog_cnt_q == 32'(WDOG_LIMIT - 1));

   always_ff @(posedge clk) begin
      if (reset) begin
         sleep_q <= 1'b1;
      end else if (!rst_pin_s) begin
         sleep_q <= 1'b1; // [RULE12]
      end else if (wake_any) begin
         sleep_q <= 1'b0; // [RULE14]
      end
   end

   // Watchdog restarted by any good frame
   always_ff @(posedge clk) begin
      if (reset || !rst_pin_s) begin
         wdog_run_q <= 1'b0;
         wdog_cnt_q <= 32'h00000000;
         wdog_exp_q <= 1'b0;
      end else if (rst_rise || frame_ok) begin
         wdog_run_q <= 1'b1; // [RULE13]
         wdog_cnt_q <= 32'h00000000;
      end else if (wdog_done) begin
         wdog_run_q <= 1'b0;
         wdog_exp_q <= 1'b1;
      end else if (wdog_run_q) begin
         wdog_cnt_q <= wdog_cnt_q + 32'h00000001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fsafe_q <= 1'b0;
      end else begin
         fsafe_q <= vdd_fail_s || wdog_exp_q; // [RULE17]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output drive: direct, pwm or serial control
   logic [7:0] pwm_cnt_q;

   // Pwm time base from edges on the first direct input
   always_ff @(posedge clk) begin
      if (reset) begin
         pwm_cnt_q <= 8'h00;
      end else if (pwm_tick) begin
         pwm_cnt_q <= pwm_cnt_q + 8'h01; // [RULE16]
      end
   end

   wire pwm_on = mode[switch_serial_pkg::MODE_PWM_ON];
   wire pwm_level = pwm_cnt_q < regs_q[switch_serial_pkg::REG_PWM_DUTY][7:0];
   wire [3:0] spi_out = regs_q[switch_serial_pkg::REG_OUT_CTRL][3:0];
   wire [3:0] direct_en = mode[switch_serial_pkg::MODE_DIRECT_LSB +: 4];
   logic [3:0] out_d;

   for (genvar ch = 0; ch < 4; ch++) begin : g_ch
      // Fail-safe hands every channel to its pin unless asleep; channel 0 pin is the pwm clock when pwm runs
      assign out_d[ch] = sleep_q ? 1'b0 :
                         fsafe_q ? din_s[ch] : // [RULE17]
                         (direct_en[ch] && !(pwm_on && ch == 0)) ? din_s[ch] : // [RULE15]
                         pwm_on ? (spi_out[ch] && pwm_level) : spi_out[ch]; // [RULE16]
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         out_state_q <= 4'h0;
         high_side_outputs <= 4'h0;
         fault_flag_out <= 1'b0;
         fault_flag_oe <= 1'b0;
         sense_temp_sel <= 1'b0;
         sense_channel <= 2'h0;
         current_sense_oe <= 1'b0;
         sleeping <= 1'b1;
         fail_safe <= 1'b0;
      end else begin
         out_state_q <= out_d;
         high_side_outputs <= out_d;
         fault_flag_oe <= (|channel_fault) || fsafe_q; // [RULE11]
         sense_temp_sel <= mode[switch_serial_pkg::MODE_SENSE_TEMP]; // [RULE18]
         sense_channel <= mode[switch_serial_pkg::MODE_SENSE_CH_LSB +: 2];
         current_sense_oe <= !mode[switch_serial_pkg::MODE_SENSE_HIZ] && !sleep_q; // [RULE18]
         sleeping <= sleep_q;
         fail_safe <= fsafe_q;
      end
   end
endmodule
`default_nettype wire

//--- design/switch_serial_pkg.sv
package switch_serial_pkg;
   // Frame layout
   localparam int FRAME_BITS = 16;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 11;
   localparam int DATA_BITS = 11;
   localparam int NUM_REGS = 32;
   localparam logic [10:0] REG_RESET = 11'h000;
   // Register indices inside the device
   localparam logic [4:0] REG_OUT_CTRL = 5'h01;
   localparam logic [4:0] REG_MODE = 5'h02;
   localparam logic [4:0] REG_PWM_DUTY = 5'h03;
   // Fields of the mode register
   localparam int MODE_DIRECT_LSB = 0;
   localparam int MODE_PWM_ON = 4;
   localparam int MODE_SENSE_TEMP = 5;
   localparam int MODE_SENSE_HIZ = 6;
   localparam int MODE_SENSE_CH_LSB = 7;
   // Clock rate and link timing
   localparam int CLK_MHZ = 40;
   localparam int LEAD_NS = 500;
   localparam int LAG_NS = 60;
   localparam int CS_GAP_NS = 1000;
   localparam int LEAD_CYCLES = (LEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int LAG_CYCLES = (LAG_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYCLES = (CS_GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int SCLK_HALF_CYCLES = 4;
   localparam int RESET_SCLK_PULSES = 4;
   // Watchdog window in microseconds
   localparam int WDOG_US = 1000;
   localparam int WDOG_CYCLES = WDOG_US * CLK_MHZ;
   localparam int PWM_STEPS = 256;
endpackage

//--- design/serial_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface serial_link_if;
   logic cs_n;
   logic sclk;
   logic si;
   logic so_out;
   logic so_oe;
   logic so;
   // Resolved data wire, idle high as if pulled up
   assign so = so_oe ? so_out : 1'b1;
   modport device (input cs_n, input sclk, input si, output so_out, output so_oe);
   modport host (output cs_n, output sclk, output si, input so);
endinterface
`default_nettype wire

//--- design/sync2.sv
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;
   // Two flops, the first read only by the second
   always_ff @(posedge clk) begin
      meta_q <= din;
      dout <= meta_q;
   end
endmodule
`default_nettype wire

//--- design/switch_serial_host.sv
`timescale 1ns/100ps
`default_nettype none
module switch_serial_host (
   input wire logic clk,
   input wire logic reset,
   serial_link_if.host link,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_word,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_word
);
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_LEAD = 5'b00010,
      S_BITS = 5'b00100,
      S_LAG = 5'b01000,
      S_GAP = 5'b10000
   } host_state_t;

   host_state_t state_q;
   logic [7:0] tmr_q;
   logic [4:0] bit_q;
   logic [15:0] tx_q;
   logic [15:0] rx_q;
   logic so_s;
   logic [3:0] boot_q;

   sync2 #(.WIDTH(1)) u_so (.clk(clk), .din(link.so), .dout(so_s));

   // Timer phase decodes
   wire tmr_zero = (tmr_q == 8'h00);
   wire half_end = (tmr_q == 8'(switch_serial_pkg::SCLK_HALF_CYCLES - 1));
   wire boot_done = (boot_q == 4'(2 * switch_serial_pkg::RESET_SCLK_PULSES));

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= S_IDLE;
         tmr_q <= 8'h00;
         bit_q <= 5'h00;
         tx_q <= 16'h0000;
         rx_q <= 16'h0000;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         link.si <= 1'b0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_word <= 16'h0000;
         boot_q <= 4'h0;
      end else begin
         rsp_valid <= 1'b0;
         tmr_q <= tmr_zero ? 8'h00 : tmr_q - 8'h01;
         unique case (state_q)
            S_IDLE: begin
               // Dummy clocks with select high bring the far side out of reset
               if (!boot_done) begin
                  boot_q <= boot_q + 4'h1;
                  link.sclk <= !link.sclk;
               end else if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  link.cs_n <= 1'b0; // [RULE9]
                  link.si <= cmd_word[15]; // [RULE3]
                  tx_q <= {cmd_word[14:0], 1'b0};
                  tmr_q <= 8'(switch_serial_pkg::LEAD_CYCLES);
                  state_q <= S_LEAD;
               end else begin
                  cmd_ready <= 1'b1;
               end
            end
            S_LEAD: begin
               if (tmr_zero) begin
                  link.sclk <= 1'b1;
                  bit_q <= 5'h00;
                  tmr_q <= 8'(switch_serial_pkg::SCLK_HALF_CYCLES - 1);
                  state_q <= S_BITS;
               end
            end
            S_BITS: begin
               if (tmr_zero) begin
                  tmr_q <= 8'(switch_serial_pkg::SCLK_HALF_CYCLES - 1);
                  if (link.sclk) begin
                     // Falling edge: far side samples, read its bit
                     link.sclk <= 1'b0;
                     rx_q <= {rx_q[14:0], so_s};
                     bit_q <= bit_q + 5'h01;
                     if (bit_q == 5'd15) begin
                        tmr_q <= 8'(switch_serial_pkg::LAG_CYCLES);
                        state_q <= S_LAG;
                     end
                  end else begin
                     link.sclk <= 1'b1;
                     link.si <= tx_q[15];
                     tx_q <= {tx_q[14:0], 1'b0};
                  end
               end else if (half_end && !link.sclk) begin
                  link.si <= link.si;
               end
            end
            S_LAG: begin
               if (tmr_zero) begin
                  link.cs_n <= 1'b1; // [RULE10]
                  rsp_valid <= 1'b1;
                  rsp_word <= rx_q;
                  tmr_q <= 8'(switch_serial_pkg::GAP_CYCLES);
                  state_q <= S_GAP;
               end
            end
            S_GAP: begin
               if (tmr_zero) begin
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- tb/switch_serial_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module switch_serial_link_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   input wire logic so_oe,
   input wire logic so
);
   logic [5:0] since_q;
   logic [5:0] rises_q;
   logic sclk_q;
   logic armed;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////
   // Idle clock pulses after reset are skipped until armed
   assign armed = since_q == 6'h3f;
   always_ff @(posedge clk) begin
      if (reset) since_q <= 6'h00;
      else if (!armed) since_q <= since_q + 6'h01;
   end
   // Rising clock edges seen in the current frame
   always_ff @(posedge clk) begin
      sclk_q <= sclk;
      if (reset || cs_n) rises_q <= 6'h00;
      else if (sclk && !sclk_q) rises_q <= rises_q + 6'h01;
   end
   ////////////////////////////////////////////////////////////
   property p_so_drive;
      so_oe == !cs_n && (!cs_n || so);
   endproperty
   a_so_drive: assert property (p_so_drive) else $error("data out driven while deselected");
   property p_sel_lead;
      $fell(cs_n) |-> !sclk [*8];
   endproperty
   a_sel_lead: assert property (p_sel_lead) else $error("select fell with clock high");
   property p_desel_quiet;
      $rose(cs_n) |-> !sclk ##1 (cs_n && !sclk) [*8];
   endproperty
   a_desel_quiet: assert property (p_desel_quiet) else $error("bad deselect or gap");
   property p_idle_low;
      armed && cs_n |-> !sclk;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("clock moves while idle");
   property p_half;
      armed && $rose(sclk) |-> sclk [*4] ##1 !sclk [*4];
   endproperty
   a_half: assert property (p_half) else $error("clock phase length wrong");
   property p_count;
      $rose(cs_n) |-> rises_q == 6'h10;
   endproperty
   a_count: assert property (p_count) else $error("frame not sixteen bits");
   property p_si_hold;
      !cs_n && $fell(sclk) |-> $stable(si);
   endproperty
   a_si_hold: assert property (p_si_hold) else $error("data in moved at sample edge");
   property p_so_hold;
      !cs_n && $fell(sclk) |=> $stable(so) [*2];
   endproperty
   a_so_hold: assert property (p_so_hold) else $error("data out moved in low phase");
endmodule
`default_nettype wire

//--- tb/test_switch_serial_control_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_switch_serial_control_port;
   logic clk;
   logic reset;
   logic reset_pin_n;
   logic [3:0] direct_inputs;
   logic [3:0] channel_fault;
   logic vdd_fail;
   logic cmd_valid;
   logic [15:0] cmd_word;
   logic cmd_ready;
   logic rsp_valid;
   logic [15:0] rsp_word;
   logic [3:0] high_side_outputs;
   logic fault_flag_out;
   logic fault_flag_oe;
   logic sense_temp_sel;
   logic [1:0] sense_channel;
   logic current_sense_oe;
   logic sleeping;
   logic fail_safe;
   int num_errors;
   int checks_done;
   int i;
   serial_link_if serial_link_if_i ();
   switch_serial_device #(.WDOG_LIMIT(3000)) switch_serial_device_i (
      .clk(clk), .reset(reset), .link(serial_link_if_i.device), .reset_pin_n(reset_pin_n),
      .wake(1'b0), .direct_inputs(direct_inputs), .vdd_fail(vdd_fail), .channel_fault(channel_fault),
      .high_side_outputs(high_side_outputs), .fault_flag_out(fault_flag_out),
      .fault_flag_oe(fault_flag_oe), .sense_temp_sel(sense_temp_sel), .sense_channel(sense_channel),
      .current_sense_oe(current_sense_oe), .sleeping(sleeping), .fail_safe(fail_safe));
   switch_serial_host switch_serial_host_i (
      .clk(clk), .reset(reset), .link(serial_link_if_i.host), .cmd_valid(cmd_valid),
      .cmd_word(cmd_word), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word));
   switch_serial_link_props switch_serial_link_props_i (
      .clk(clk), .reset(reset), .cs_n(serial_link_if_i.cs_n), .sclk(serial_link_if_i.sclk),
      .si(serial_link_if_i.si), .so_oe(serial_link_if_i.so_oe), .so(serial_link_if_i.so));
   ////////////////////////////////////////////////////////////
   // Clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Compare one value
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   // A wait that ran out of time
   task automatic timed_out(input string what);
      $display("wrong value %s expected done seen timeout", what);
      num_errors++;
      report_and_stop();
   endtask
   // Let n edges pass, then look where values are settled
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // One frame through the host; status reply compared
   task automatic send(input logic [15:0] w, input logic [15:0] status);
      @(posedge clk);
      for (i = 0; i < 400 && cmd_ready !== 1'b1; i++) @(posedge clk);
      if (i == 400) timed_out("ready");
      cmd_valid <= 1'b1;
      cmd_word <= w;
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(negedge clk);
      if (i == 400) timed_out("response");
      check("status word", status, rsp_word);
      settle(6);
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      num_errors = 0;
      checks_done = 0;
      reset = 1'b1;
      reset_pin_n = 1'b1;
      direct_inputs = 4'h0;
      channel_fault = 4'h0;
      vdd_fail = 1'b0;
      cmd_valid = 1'b0;
      cmd_word = 16'h0000;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      reset_pin_n <= 1'b0;
      settle(20);
      check("sleep in reset", 16'h0001, 16'(sleeping));
      @(posedge clk);
      reset_pin_n <= 1'b1;
      settle(10);
      check("sleep after pin", 16'h0000, 16'(sleeping));
      send({switch_serial_pkg::REG_OUT_CTRL, 11'h005}, 16'h0000);
      check("outputs", 16'h0005, 16'(high_side_outputs));
      @(posedge clk);
      channel_fault <= 4'h2;
      settle(6);
      check("flag pulled", 16'h0001, 16'(fault_flag_oe));
      check("flag level", 16'h0000, 16'(fault_flag_out));
      send({switch_serial_pkg::REG_PWM_DUTY, 11'h000}, 16'h2500);
      @(posedge clk);
      channel_fault <= 4'h0;
      settle(6);
      check("flag released", 16'h0000, 16'(fault_flag_oe));
      send({switch_serial_pkg::REG_MODE, 11'h160}, 16'h0500);
      check("sense temp", 16'h0001, 16'(sense_temp_sel));
      check("sense channel", 16'h0002, 16'(sense_channel));
      check("sense hiz", 16'h0000, 16'(current_sense_oe));
      send({switch_serial_pkg::REG_OUT_CTRL, 11'h000}, 16'h0500);
      check("outputs off", 16'h0000, 16'(high_side_outputs));
      send({switch_serial_pkg::REG_MODE, 11'h00f}, 16'h0000);
      @(posedge clk);
      direct_inputs <= 4'ha;
      settle(8);
      check("direct outputs", 16'h000a, 16'(high_side_outputs));
      @(posedge clk);
      vdd_fail <= 1'b1;
      settle(6);
      check("supply loss", 16'h0001, 16'(fail_safe));
      check("fail-safe outputs", 16'h000a, 16'(high_side_outputs));
      @(posedge clk);
      vdd_fail <= 1'b0;
      settle(6);
      check("no fail-safe", 16'h0000, 16'(fail_safe));
      for (i = 0; i < 3500 && fail_safe !== 1'b1; i++) @(negedge clk);
      if (i == 3500) timed_out("watchdog");
      check("watchdog late", 16'h0001, 16'(i > 2900));
      report_and_stop();
   end
endmodule
`default_nettype wire
